// >>> ext_osc_defs.svh
/*
 external oscillator control register: offsets, field positions, reset values, codes.
 assumes an 8-bit special-function register bus with a page select.
*/
`ifndef EXT_OSC_DEFS_SVH
`define EXT_OSC_DEFS_SVH
`define EXT_OSC_ADDR        8'h9f
`define EXT_OSC_PAGE        8'h0f
`define EXT_OSC_RESET       8'h00
`define EXT_OSC_VALID_BIT   7
`define EXT_OSC_MODE_HI     6
`define EXT_OSC_MODE_LO     4
`define EXT_OSC_FREQ_HI     2
`define EXT_OSC_FREQ_LO     0
`define EXT_OSC_MODE_OFF    3'h0
`define EXT_OSC_MODE_CMOS   3'h2
`define EXT_OSC_MODE_CMOS2  3'h3
`define EXT_OSC_MODE_RC     3'h4
`define EXT_OSC_MODE_CAP    3'h5
`define EXT_OSC_MODE_XTL    3'h6
`define EXT_OSC_MODE_XTL2   3'h7
`define EXT_OSC_CODE_ZERO   3'h0
`endif

// >>> ext_osc_pkg.sv
/*
 types shared by the oscillator control register modules.
 assumes nothing beyond the defines header.
*/
package ext_osc_pkg;
    typedef enum logic [2:0] {
        osc_off,
        osc_cmos,
        osc_cmos_div2,
        osc_rc,
        osc_cap,
        osc_xtl,
        osc_xtl_div2
    } osc_kind_e;
    // k factor in hundredths, one entry per frequency code
    typedef logic [17:0] kfac_t;
endpackage : ext_osc_pkg

// >>> osc_cfg_if.sv
/*
 interface carrying decoded oscillator settings between the register and the decoder.
 assumes a single clock domain.
*/
`timescale 1ns/1ns
interface osc_cfg_if;
    import ext_osc_pkg::*;
    logic [2:0]  mode;   // raw mode field
    logic [2:0]  freq;   // raw frequency code
    osc_kind_e   kind;   // decoded oscillator kind
    logic        xtl;    // crystal mode selected
    logic        div2;   // divide by two stage selected
    logic        rc_or_xtl_range; // freq code is a range
    kfac_t       kfac;   // k factor in hundredths
    modport reg_side (output mode, output freq, input kind, input xtl, input div2,
                      input rc_or_xtl_range, input kfac);
    modport dec_side (input mode, input freq, output kind, output xtl, output div2,
                      output rc_or_xtl_range, output kfac);
endinterface : osc_cfg_if

// >>> osc_mode_decode.sv
/*
 combinational decode of mode field and frequency code.
 assumes the register side drives mode and freq.
*/
`timescale 1ns/1ns
`include "ext_osc_defs.svh"
module osc_mode_decode
    import ext_osc_pkg::*;
(
    osc_cfg_if.dec_side cfg   // settings from the register
);
    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    always_comb
    begin
        cfg.kind            = osc_off;
        cfg.xtl             = 1'b0;
        cfg.div2            = 1'b0;
        cfg.rc_or_xtl_range = 1'b0;
        case (cfg.mode)
            `EXT_OSC_MODE_CMOS:  cfg.kind = osc_cmos;
            `EXT_OSC_MODE_CMOS2:
            begin
                cfg.kind = osc_cmos_div2;
                cfg.div2 = 1'b1;
            end
            `EXT_OSC_MODE_RC:
            begin
                cfg.kind            = osc_rc;
                cfg.rc_or_xtl_range = 1'b1;
            end
            `EXT_OSC_MODE_CAP:   cfg.kind = osc_cap;
            `EXT_OSC_MODE_XTL:
            begin
                cfg.kind            = osc_xtl;
                cfg.xtl             = 1'b1;
                cfg.rc_or_xtl_range = 1'b1;
            end
            `EXT_OSC_MODE_XTL2:
            begin
                cfg.kind            = osc_xtl_div2;
                cfg.xtl             = 1'b1;
                cfg.div2            = 1'b1;
                cfg.rc_or_xtl_range = 1'b1;
            end
            default: cfg.kind = osc_off;
        endcase
    end

    // ----------------------------------------
    // k factor table for capacitor mode, decoded from freq in every mode
    // ----------------------------------------
    always_comb
    begin
        case (cfg.freq)
            3'h0:    cfg.kfac = 18'h00057;                    // 0.87
            3'h1:    cfg.kfac = 18'h00104;                    // 2.6
            3'h2:    cfg.kfac = 18'h00302;                    // 7.7
            3'h3:    cfg.kfac = 18'h00898;                    // 22
            3'h4:    cfg.kfac = 18'h00258;                    // 6
            3'h5:    cfg.kfac = 18'h04650;                    // 180
            3'h6:    cfg.kfac = 18'h10360;                    // 664
            default: cfg.kfac = 18'h26d18;                    // 1590
        endcase
    end
endmodule : osc_mode_decode

// >>> ext_osc_ctrl.sv
/*
 external oscillator control and status register on the special-function bus.
 assumes a cpu bus with write/read strobes, an 8-bit address and a page register;
 read data is registered one cycle after the read strobe.
*/
`timescale 1ns/1ns
`include "ext_osc_defs.svh"
// Contract
// - register lives at address 0x9f, only while page 0x0f is selected.
// - bit 7 read-only crystal valid flag, meaningful in crystal modes.
// - mode bits 6:4; 110 crystal, 111 crystal divide by two.
// - bit 3 unused, always reads zero.
// - bits 2:0 frequency range for crystal or rc, k factor for capacitor.
// - capacitor codes map to k factors 0.87 up to 1590.
module ext_osc_ctrl
    import ext_osc_pkg::*;
(
    input  wire logic        clock,        // system clock
    input  wire logic        rst,          // async reset, active high
    input  wire logic [7:0]  sfr_addr,     // register address
    input  wire logic [7:0]  sfr_page,     // selected page
    input  wire logic        sfr_wr,       // write strobe
    input  wire logic        sfr_rd,       // read strobe
    input  wire logic [7:0]  sfr_wdata,    // write data
    input  wire logic        xtl_stable,   // crystal running and stable
    output logic      [7:0]  sfr_rdata,    // read data
    output logic             sfr_rvalid,   // read data valid pulse
    output logic      [2:0]  ext_osc_mode_select, // mode field
    output logic      [2:0]  ext_osc_freq_code,   // frequency code
    output logic             crystal_valid_flag,  // valid flag
    output logic             osc_enable,   // oscillator powered
    output logic             osc_div2,     // divide by two stage on
    output logic             osc_xtl_mode  // crystal mode selected
);
    osc_cfg_if cfg ();

    logic [2:0] mode_r, mode_nxt;
    logic [2:0] freq_r, freq_nxt;
    logic       valid_r, valid_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       rvalid_r, rvalid_nxt;
    logic       en_r, en_nxt;
    logic       div2_r, div2_nxt;
    logic       xtlm_r, xtlm_nxt;
    logic       hit;

    assign cfg.mode = mode_r;
    assign cfg.freq = freq_r;

    osc_mode_decode u_dec (
        .cfg (cfg.dec_side)
    );

    // ----------------------------------------
    // decode and next state
    // ----------------------------------------
    assign hit = (sfr_addr == `EXT_OSC_ADDR) && (sfr_page == `EXT_OSC_PAGE);

    always_comb
    begin
        mode_nxt   = mode_r;
        freq_nxt   = freq_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        if (sfr_wr && hit)
        begin
            // bit 3 and bit 7 writes are dropped
            mode_nxt = sfr_wdata[`EXT_OSC_MODE_HI:`EXT_OSC_MODE_LO];
            freq_nxt = sfr_wdata[`EXT_OSC_FREQ_HI:`EXT_OSC_FREQ_LO];
        end
        if (sfr_rd)
        begin
            rvalid_nxt = 1'b1;
            // unmapped reads return zero
            rdata_nxt  = hit ? {valid_r, mode_r, 1'b0, freq_r} : `EXT_OSC_RESET;
        end
        // flag only qualifies in crystal modes; cleared otherwise, one cycle after mode_r leaves them, so stale lock shows for at most one cycle
        valid_nxt = cfg.xtl & xtl_stable;
        en_nxt    = (cfg.kind != osc_off);
        div2_nxt  = cfg.div2;
        xtlm_nxt  = cfg.xtl;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            mode_r   <= `EXT_OSC_MODE_OFF;
            freq_r   <= `EXT_OSC_CODE_ZERO;
            valid_r  <= 1'b0;
            rdata_r  <= `EXT_OSC_RESET;
            rvalid_r <= 1'b0;
            en_r     <= 1'b0;
            div2_r   <= 1'b0;
            xtlm_r   <= 1'b0;
        end
        else
        begin
            mode_r   <= mode_nxt;
            freq_r   <= freq_nxt;
            valid_r  <= valid_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            en_r     <= en_nxt;
            div2_r   <= div2_nxt;
            xtlm_r   <= xtlm_nxt;
        end
    end

    assign sfr_rdata           = rdata_r;
    assign sfr_rvalid          = rvalid_r;
    assign ext_osc_mode_select = mode_r;
    assign ext_osc_freq_code   = freq_r;
    assign crystal_valid_flag  = valid_r;
    assign osc_enable          = en_r;
    assign osc_div2            = div2_r;
    assign osc_xtl_mode        = xtlm_r;
endmodule : ext_osc_ctrl

// >>> ext_osc_ctrl_monitor.sv
/*
 port checker for the oscillator control register.
 assumes it is bound onto ext_osc_ctrl, one clock domain.
*/
`timescale 1ns/1ns
module ext_osc_ctrl_monitor
(
    input wire logic       clock,               // clock
    input wire logic       rst,                 // reset
    input wire logic [7:0] sfr_addr,            // addr
    input wire logic [7:0] sfr_page,            // page
    input wire logic       sfr_wr,              // write
    input wire logic       sfr_rd,              // read
    input wire logic [7:0] sfr_wdata,           // wdata
    input wire logic       xtl_stable,          // stable
    input wire logic [7:0] sfr_rdata,           // rdata
    input wire logic       sfr_rvalid,          // rvalid
    input wire logic [2:0] ext_osc_mode_select, // mode
    input wire logic [2:0] ext_osc_freq_code,   // freq
    input wire logic       crystal_valid_flag,  // valid
    input wire logic       osc_enable,          // on
    input wire logic       osc_div2,            // div2
    input wire logic       osc_xtl_mode         // xtl
);
    // --------------------
    // properties
    // --------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    wire       hit   = sfr_addr == 8'h9f && sfr_page == 8'h0f;
    wire [2:0] wmode = sfr_wdata[6:4];
    wire [2:0] wfreq = sfr_wdata[2:0];
    sequence s_hit_wr; sfr_wr && hit; endsequence
    sequence s_xtl_wr; s_hit_wr ##0 sfr_wdata[6:5] == 2'b11; endsequence
    property p_wr; s_hit_wr |=> ext_osc_mode_select == $past(wmode)
        && ext_osc_freq_code == $past(wfreq); endproperty
    a_wr: assert property (p_wr) else $error("write not taken");
    property p_miss; !(sfr_wr && hit) |=> $stable(ext_osc_mode_select) && $stable(ext_osc_freq_code); endproperty
    a_miss: assert property (p_miss) else $error("stray write taken");
    property p_rd; 1 |=> sfr_rvalid == $past(sfr_rd); endproperty
    a_rd: assert property (p_rd) else $error("read answer wrong");
    property p_rd_miss; sfr_rd && !hit |=> sfr_rdata == 8'h00; endproperty
    a_rd_miss: assert property (p_rd_miss) else $error("unmapped read not zero");
    property p_rd_hit; sfr_rd && hit |=> sfr_rdata == {$past(crystal_valid_flag),
        $past(ext_osc_mode_select), 1'b0, $past(ext_osc_freq_code)}; endproperty
    a_rd_hit: assert property (p_rd_hit) else $error("read byte wrong");
    property p_bit3; sfr_rvalid |-> !sfr_rdata[3]; endproperty
    a_bit3: assert property (p_bit3) else $error("unused bit set");
    property p_valid; 1 |=> crystal_valid_flag ==
        ($past(ext_osc_mode_select) >= 3'h6 && $past(xtl_stable)); endproperty
    a_valid: assert property (p_valid) else $error("valid flag wrong");
    property p_div2; 1 |=> osc_div2 == ($past(ext_osc_mode_select) inside {3'h3, 3'h7}); endproperty
    a_div2: assert property (p_div2) else $error("divide stage wrong");
    property p_xtl; s_xtl_wr ##1 !sfr_wr |=> osc_xtl_mode && osc_enable; endproperty
    a_xtl: assert property (p_xtl) else $error("crystal mode not set");
endmodule : ext_osc_ctrl_monitor
bind ext_osc_ctrl ext_osc_ctrl_monitor mon (
    .clock               (clock),
    .rst                 (rst),
    .sfr_addr            (sfr_addr),
    .sfr_page            (sfr_page),
    .sfr_wr              (sfr_wr),
    .sfr_rd              (sfr_rd),
    .sfr_wdata           (sfr_wdata),
    .xtl_stable          (xtl_stable),
    .sfr_rdata           (sfr_rdata),
    .sfr_rvalid          (sfr_rvalid),
    .ext_osc_mode_select (ext_osc_mode_select),
    .ext_osc_freq_code   (ext_osc_freq_code),
    .crystal_valid_flag  (crystal_valid_flag),
    .osc_enable          (osc_enable),
    .osc_div2            (osc_div2),
    .osc_xtl_mode        (osc_xtl_mode)
);

// >>> ext_osc_ctrl_tb.sv
/*
 self-checking bench for the oscillator control register.
 assumes the design ports as declared; inputs change at the falling edge.
*/
`timescale 1ns/1ns
module ext_osc_ctrl_tb;
    logic       clock = 0, rst = 1, wr = 0, rd = 0, stable = 0;
    logic [7:0] addr = 0, page = 0, wdata = 0, rdata;
    logic       rvalid, valid, en, div2, xtl;
    logic [2:0] mode, freq;
    int         n_fail = 0, n_tests = 0;
    // capacitor k factors in hundredths, indexed by frequency code
    logic [17:0] kfac_exp [8] = '{18'h00057, 18'h00104, 18'h00302, 18'h00898,
                                  18'h00258, 18'h04650, 18'h10360, 18'h26d18};
    always #5 clock = ~clock;
    ext_osc_ctrl dut (.clock(clock), .rst(rst), .sfr_addr(addr), .sfr_page(page), .sfr_wr(wr), .sfr_rd(rd),
        .sfr_wdata(wdata), .xtl_stable(stable), .sfr_rdata(rdata), .sfr_rvalid(rvalid),
        .ext_osc_mode_select(mode), .ext_osc_freq_code(freq), .crystal_valid_flag(valid),
        .osc_enable(en), .osc_div2(div2), .osc_xtl_mode(xtl));
    // --------------------
    // tasks
    // --------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one strobe; the extra cycle lets the derived outputs settle
    task automatic access(input logic w, input logic [7:0] a, p, d);
        @(negedge clock);
        {wr, rd, addr, page, wdata} = {w, !w, a, p, d};
        @(negedge clock);
        {wr, rd} = 2'b00;
        check({7'h0, rvalid}, {7'h0, !w});
        @(negedge clock);
    endtask : access
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    // --------------------
    // tests
    // --------------------
    initial
    begin
        repeat (5) @(posedge clock);
        @(negedge clock) rst = 0;
        check({valid, mode, en, div2, xtl, 1'b0}, 8'h00);
        check({5'h0, freq}, 8'h00);
        access(0, 8'h9f, 8'h0f, 8'h00);
        check(rdata, 8'h00);
        for (int m = 0; m < 8; m++)
        begin
            stable = m[0];
            access(1, 8'h9f, 8'h0f, {1'b1, m[2:0], 1'b1, 3'(7 - m)});
            access(0, 8'h9f, 8'h0f, 8'h00);
            check(rdata, {m[2:0] == 3'h7, m[2:0], 1'b0, 3'(7 - m)});
            check({5'h0, en, div2, xtl}, {5'h0, m > 1, m[1:0] == 2'b11, m[2:1] == 2'b11});
            for (int b = 0; b < 3; b++)
            begin
                check(8'(dut.cfg.kfac >> (8 * b)), 8'(kfac_exp[7 - m] >> (8 * b)));
            end
        end
        stable = 0;
        repeat (2) @(negedge clock);
        check({7'h0, valid}, 8'h00);
        access(1, 8'h9e, 8'h0f, 8'h25);
        access(1, 8'h9f, 8'h0e, 8'h25);
        access(0, 8'h9f, 8'h0e, 8'h00);
        check(rdata, 8'h00);
        check({2'h0, mode, freq}, 8'h38);
        @(negedge clock) rst = 1;
        @(negedge clock) rst = 0;
        check({2'h0, mode, freq}, 8'h00);
        check({5'h0, en, div2, xtl}, 8'h00);
        access(0, 8'h9f, 8'h0f, 8'h00);
        check(rdata, 8'h00);
        final_report;
    end
    // a run needs about 72 cycles; over ten times that means a hang
    initial
    begin
        repeat (1000) @(posedge clock);
        n_fail++;
        final_report;
    end
endmodule : ext_osc_ctrl_tb
